// >>> hdl/umc_pkg.sv
// ****************************************************************************
// Shared constants for the modem control and loopback block
// ****************************************************************************
package umc_pkg;

  // Register byte addresses (word aligned on the 32-bit bus)
  localparam logic [7:0] LINE_CTRL_OFS     = 8'h0C;  // Line control, index 03h
  localparam logic [7:0] HS_CTRL_OFS       = 8'h10;  // Line handshake control, index 04h
  localparam logic [7:0] MODEM_STAT_OFS    = 8'h18;  // Modem status, index 06h
  localparam logic [7:0] EVT_STAT_OFS      = 8'h20;  // Sticky event status
  localparam logic [7:0] EVT_CLR_OFS       = 8'h24;  // Event clear, write only
  localparam logic [7:0] EVT_EN_OFS        = 8'h28;  // Event enable
  localparam logic [7:0] IRQ_EN_OFS        = 8'h2C;  // Interrupt enable (rx, tx, modem)

  // Handshake control field positions
  localparam int HS_DTR_BIT   = 0;
  localparam int HS_RTS_BIT   = 1;
  localparam int HS_AUX1_BIT  = 2;
  localparam int HS_AUX2_BIT  = 3;
  localparam int HS_LOOP_BIT  = 4;
  localparam int HS_WIDTH     = 5;
  localparam logic [HS_WIDTH-1:0] HS_CTRL_RST = 5'h00;

  // Line control word length field
  localparam int LC_WLEN_LSB  = 0;
  localparam int LC_WLEN_W    = 2;
  localparam logic [7:0] LINE_CTRL_RST = 8'h00;

  // Event status bit positions
  localparam int EV_MSR_BIT   = 0;  // Modem status change
  localparam int EV_RX_BIT    = 1;  // Character received
  localparam int EV_TX_BIT    = 2;  // Character sent
  localparam int EV_WIDTH     = 3;

  // Word length codes
  typedef enum logic [1:0] {
    WLEN_5 = 2'b00,
    WLEN_6 = 2'b01,
    WLEN_7 = 2'b10,
    WLEN_8 = 2'b11
  } umc_wlen_t;

endpackage : umc_pkg

// >>> hdl/umc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************************
// Three-stage pin synchroniser, change accepted when stages two and three agree
// ****************************************************************************
module umc_sync #(
  parameter int W = 5
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  input  wire logic [W-1:0] rst_val_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] s1_ff;   // Metastability stage, read only by s2
  logic [W-1:0] s2_ff;   // Second stage
  logic [W-1:0] s3_ff;   // Third stage
  logic [W-1:0] out_ff;  // Filtered level
  logic         init_ff; // Loads reset value once after release

  // Shift chain; constants under reset, pins idle high
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Per-bit agreement filter
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_ff  <= '1;
      init_ff <= 1'b0;
    end else begin
      init_ff <= 1'b1;
      for (int i = 0; i < W; i++) begin
        if (!init_ff) begin
          out_ff[i] <= rst_val_i[i];
        end else if (s2_ff[i] == s3_ff[i]) begin
          out_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign sync_o = out_ff;

  initial begin
    if (W < 1) $error("umc_sync: width must be at least one");
  end
endmodule : umc_sync
`default_nettype wire

// >>> hdl/umc_top.sv
`timescale 1ns/1ns
`default_nettype none
module umc_top (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  // Avalon-MM slave
  input  wire logic [7:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output var  logic [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  output var  logic                  avs_response_err_o,
  // Serial path to and from the transmit and receive shifters
  input  wire logic                  tsr_out_i,
  input  wire logic                  tx_idle_i,
  input  wire logic                  rx_pin_i,
  output logic                       ser_tx_o,
  output logic                       rsr_in_o,
  output logic [1:0]                 word_len_o,
  output logic [3:0]                 data_bits_o,
  // Character events from the shifters (same clock)
  input  wire logic                  rx_char_i,
  input  wire logic                  tx_char_i,
  // Active-low handshake pins
  input  wire logic                  clear_to_send_n_i,
  input  wire logic                  set_ready_n_i,
  input  wire logic                  ring_indicator_n_i,
  input  wire logic                  carrier_detect_n_i,
  output logic                       request_to_send_n_o,
  output logic                       terminal_ready_n_o,
  // Interrupt pin as two signals, plus level event interrupt
  output logic                       irq_o,
  output logic                       irq_oe_o,
  output logic                       evt_irq_o
);
  import umc_pkg::*;

  // ****************************************************************************
  // Bus slave
  // ****************************************************************************
  logic [HS_WIDTH-1:0] hs_ctrl_ff;    // Handshake control bits 4:0
  logic [7:0]          line_ctrl_ff;  // Line control byte
  logic [3:0]          msr_delta_ff;  // Modem status change bits
  logic [3:0]          msr_prev_ff;   // Last seen modem status (active high)
  logic [EV_WIDTH-1:0] evt_stat_ff;   // Sticky events
  logic [EV_WIDTH-1:0] evt_en_ff;     // Event enables
  logic [2:0]          irq_en_ff;     // Rx, tx, modem interrupt enables
  logic                ack_ff;        // One wait state, then release
  logic [31:0]         nxt_rdata;     // Read mux result
  logic                addr_ok;       // Address hits a register
  logic                wr_take;       // Write committed this edge
  logic                rd_take;       // Read committed this edge
  logic [3:0]          msr_now;       // Modem status source, active high
  logic [3:0]          pins_sync_n;   // Synchronised handshake pins
  logic                rx_sync;       // Synchronised receive pin
  logic                msr_change;    // Any modem input changed
  logic                loop_on;       // Loopback active

  // Every access stalls one cycle so read data comes from a flip-flop
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
  assign wr_take = avs_write_i & ack_ff;
  assign rd_take = avs_read_i & ack_ff;
  assign loop_on = hs_ctrl_ff[HS_LOOP_BIT];

  // Handshake timing: ack raised one cycle after request appears
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
    end
  end

  // Address decode
  always_comb begin
    case (avs_address_i)
      LINE_CTRL_OFS, HS_CTRL_OFS, MODEM_STAT_OFS, EVT_STAT_OFS,
      EVT_CLR_OFS, EVT_EN_OFS, IRQ_EN_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Read mux; reserved bits read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address_i)
      LINE_CTRL_OFS:  nxt_rdata[7:0] = line_ctrl_ff;
      HS_CTRL_OFS:    nxt_rdata[HS_WIDTH-1:0] = hs_ctrl_ff;
      MODEM_STAT_OFS: nxt_rdata[7:0] = {msr_now, msr_delta_ff};
      EVT_STAT_OFS:   nxt_rdata[EV_WIDTH-1:0] = evt_stat_ff;
      EVT_EN_OFS:     nxt_rdata[EV_WIDTH-1:0] = evt_en_ff;
      IRQ_EN_OFS:     nxt_rdata[2:0] = irq_en_ff;
      default:        nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read data and error response registered at the stalled edge, one cycle before the accepting edge
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o     <= 32'h0000_0000;
      avs_response_err_o <= 1'b0;
    end else if ((avs_read_i | avs_write_i) & ~ack_ff) begin
      avs_readdata_o     <= nxt_rdata;
      avs_response_err_o <= ~addr_ok;
    end
  end

  // ****************************************************************************
  // Control registers
  // ****************************************************************************
  // Handshake control; bits 7:5 are not stored at all
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hs_ctrl_ff <= HS_CTRL_RST;
    end else if (wr_take && avs_address_i == HS_CTRL_OFS && avs_byteenable_i[0]) begin
      hs_ctrl_ff <= avs_writedata_i[HS_WIDTH-1:0];
    end
  end

  // Line control; only word length drives logic here
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_ctrl_ff <= LINE_CTRL_RST;
    end else if (wr_take && avs_address_i == LINE_CTRL_OFS && avs_byteenable_i[0]) begin
      line_ctrl_ff <= avs_writedata_i[7:0];
    end
  end

  // Enables
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_en_ff <= '0;
      irq_en_ff <= 3'h0;
    end else if (wr_take && avs_byteenable_i[0]) begin
      if (avs_address_i == EVT_EN_OFS) evt_en_ff <= avs_writedata_i[EV_WIDTH-1:0];
      if (avs_address_i == IRQ_EN_OFS) irq_en_ff <= avs_writedata_i[2:0];
    end
  end

  // ****************************************************************************
  // Word length
  // ****************************************************************************
  // Data bit count only; start, parity and stop are framed by the shifters
  always_comb begin
    case (umc_wlen_t'(line_ctrl_ff[LC_WLEN_LSB +: LC_WLEN_W]))
      WLEN_5:  data_bits_o = 4'h5;
      WLEN_6:  data_bits_o = 4'h6;
      WLEN_7:  data_bits_o = 4'h7;
      WLEN_8:  data_bits_o = 4'h8;
      default: data_bits_o = 4'h8;
    endcase
  end
  assign word_len_o = line_ctrl_ff[LC_WLEN_LSB +: LC_WLEN_W];

  // ****************************************************************************
  // Pins and loopback
  // ****************************************************************************
  umc_sync #(
    .W (5)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .async_i   ({rx_pin_i, carrier_detect_n_i, ring_indicator_n_i, set_ready_n_i, clear_to_send_n_i}),
    .rst_val_i ({5{1'b1}}),  // Idle-high start; never load raw pins unsynchronised
    .sync_o    ({rx_sync, pins_sync_n})
  );

  // Serial data: mark while looped, shifter straight into receiver
  assign ser_tx_o = loop_on ? 1'b1 : tsr_out_i;
  assign rsr_in_o = loop_on ? tsr_out_i : rx_sync;

  // Modem status order {dcd, ri, dsr, cts}; pins ignored in loopback
  always_comb begin
    if (loop_on) begin
      msr_now = {hs_ctrl_ff[HS_AUX2_BIT], hs_ctrl_ff[HS_AUX1_BIT],
                 hs_ctrl_ff[HS_DTR_BIT], hs_ctrl_ff[HS_RTS_BIT]};
    end else begin
      msr_now = ~pins_sync_n;
    end
  end

  // Outputs forced inactive in loopback
  assign request_to_send_n_o = loop_on | ~hs_ctrl_ff[HS_RTS_BIT];
  assign terminal_ready_n_o  = loop_on | ~hs_ctrl_ff[HS_DTR_BIT];

  // ****************************************************************************
  // Modem status change tracking
  // ****************************************************************************
  assign msr_change = |(msr_now ^ msr_prev_ff);

  // Delta bits: new change wins over the clearing read
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      msr_prev_ff  <= 4'h0;
      msr_delta_ff <= 4'h0;
    end else begin
      msr_prev_ff <= msr_now;
      if (rd_take && avs_address_i == MODEM_STAT_OFS) begin
        msr_delta_ff <= msr_now ^ msr_prev_ff;
      end else begin
        msr_delta_ff <= msr_delta_ff | (msr_now ^ msr_prev_ff);
      end
    end
  end

  // ****************************************************************************
  // Events and interrupts
  // ****************************************************************************
  // Sticky events; set wins over a write-one clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_stat_ff <= '0;
    end else begin
      for (int i = 0; i < EV_WIDTH; i++) begin
        if (wr_take && avs_address_i == EVT_CLR_OFS && avs_byteenable_i[0] && avs_writedata_i[i]) begin
          evt_stat_ff[i] <= 1'b0;
        end
      end
      if (msr_change) evt_stat_ff[EV_MSR_BIT] <= 1'b1;
      if (rx_char_i)  evt_stat_ff[EV_RX_BIT]  <= 1'b1;
      if (tx_char_i)  evt_stat_ff[EV_TX_BIT]  <= 1'b1;
    end
  end

  assign evt_irq_o = |(evt_stat_ff & evt_en_ff);

  // Serial port interrupt: rx/tx/modem gated by enables, pin driven only with aux two
  assign irq_o    = (irq_en_ff[0] & evt_stat_ff[EV_RX_BIT]) |
                    (irq_en_ff[1] & evt_stat_ff[EV_TX_BIT]) |
                    (irq_en_ff[2] & (|msr_delta_ff));
  assign irq_oe_o = hs_ctrl_ff[HS_AUX2_BIT];

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  sequence s_loop_set;
    loop_on ##1 loop_on;
  endsequence

  a_loop_tx_mark: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    loop_on |-> ser_tx_o) else $error("tx not marking in loopback");
  a_loop_rx_feed: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    loop_on |-> rsr_in_o == tsr_out_i) else $error("receiver not fed from shifter");
  a_loop_pins_hi: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_loop_set |-> request_to_send_n_o && terminal_ready_n_o) else $error("handshake pins low in loop");
  a_loop_msr_src: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    loop_on |-> msr_now[1] == hs_ctrl_ff[HS_DTR_BIT] && msr_now[3] == hs_ctrl_ff[HS_AUX2_BIT])
    else $error("loop status source wrong");
  a_rts_invert: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !loop_on |-> request_to_send_n_o == !hs_ctrl_ff[HS_RTS_BIT]) else $error("rts polarity wrong");
  a_dtr_invert: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !loop_on |-> terminal_ready_n_o == !hs_ctrl_ff[HS_DTR_BIT]) else $error("dtr polarity wrong");
  a_irq_gate_oe: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(hs_ctrl_ff[HS_AUX2_BIT]) |-> irq_oe_o) else $error("irq enable not following aux two");
  a_msr_change_evt: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    msr_change |=> evt_stat_ff[EV_MSR_BIT] && (|msr_delta_ff)) else $error("modem change lost");
  a_wlen_count: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    data_bits_o == 4'(word_len_o) + 4'h5) else $error("data bit count wrong");
endmodule : umc_top
`default_nettype wire

// >>> bench/umc_modem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************************
// Modem model on the far side of the handshake and serial lines
// ****************************************************************************
module umc_modem_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] lag_i,               // Answer delay in cycles, 0 is prompt
  input  wire logic       ring_n_i,            // Ring level commanded by the bench
  input  wire logic       carrier_n_i,         // Carrier level commanded by the bench
  input  wire logic       request_to_send_n_i,
  input  wire logic       terminal_ready_n_i,
  output logic            clear_to_send_n_o,
  output logic            set_ready_n_o,
  output logic            ring_indicator_n_o,
  output logic            carrier_detect_n_o,
  output logic            rx_line_o
);
  logic [15:0] rts_hist_ff;  // Past request levels, newest in bit 0
  logic [15:0] dtr_hist_ff;  // Past terminal-ready levels
  logic        rx_ff;        // Line noise, so a stale value never looks valid

  // Keep history so the answer may come late like a slow modem
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rts_hist_ff <= 16'hFFFF;
      dtr_hist_ff <= 16'hFFFF;
      rx_ff       <= 1'b1;
    end else begin
      rts_hist_ff <= {rts_hist_ff[14:0], request_to_send_n_i};
      dtr_hist_ff <= {dtr_hist_ff[14:0], terminal_ready_n_i};
      rx_ff       <= ~rx_ff;
    end
  end

  // Clear-to-send answers request-to-send, set-ready answers terminal-ready
  assign clear_to_send_n_o  = (lag_i == 4'h0) ? request_to_send_n_i : rts_hist_ff[lag_i - 4'h1];
  assign set_ready_n_o      = (lag_i == 4'h0) ? terminal_ready_n_i : dtr_hist_ff[lag_i - 4'h1];
  assign ring_indicator_n_o = ring_n_i;
  assign carrier_detect_n_o = carrier_n_i;
  assign rx_line_o          = rx_ff;
endmodule : umc_modem_model
`default_nettype wire

// >>> bench/test_uart_modem_control_loopback.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************************
// Register-level tests of handshake control, loopback and word length
// ****************************************************************************
module test_uart_modem_control_loopback;
  import umc_pkg::*;
  logic ref_clk_i, rstn_i, avs_read_i, avs_write_i, tsr_out_i, rx_char_i, tx_char_i;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic avs_waitrequest_o, avs_response_err_o, ser_tx_o, rsr_in_o, rx_line, cts_n, dsr_n, ri_n, dcd_n;
  logic rts_n, dtr_n, irq_o, irq_oe_o, evt_irq_o, ring_n, carrier_n, last_err;
  logic [1:0] word_len_o;
  logic [3:0] data_bits_o, lag;
  logic [31:0] rdat;
  int errors = 0;
  int comparisons = 0;

  umc_top umc_top_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_err_o(avs_response_err_o), .tsr_out_i(tsr_out_i), .tx_idle_i(1'b1), .rx_pin_i(rx_line),
    .ser_tx_o(ser_tx_o), .rsr_in_o(rsr_in_o), .word_len_o(word_len_o), .data_bits_o(data_bits_o),
    .rx_char_i(rx_char_i), .tx_char_i(tx_char_i), .clear_to_send_n_i(cts_n), .set_ready_n_i(dsr_n),
    .ring_indicator_n_i(ri_n), .carrier_detect_n_i(dcd_n), .request_to_send_n_o(rts_n),
    .terminal_ready_n_o(dtr_n), .irq_o(irq_o), .irq_oe_o(irq_oe_o), .evt_irq_o(evt_irq_o));

  umc_modem_model umc_modem_model_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .lag_i(lag),
    .ring_n_i(ring_n), .carrier_n_i(carrier_n), .request_to_send_n_i(rts_n), .terminal_ready_n_i(dtr_n),
    .clear_to_send_n_o(cts_n), .set_ready_n_o(dsr_n), .ring_indicator_n_o(ri_n),
    .carrier_detect_n_o(dcd_n), .rx_line_o(rx_line));

  // ****************************************************************************
  // Clock, watchdog and closing
  // ****************************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // Whole run is well under 2000 cycles, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    close_out();
  end

  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // ****************************************************************************
  // Compare and bus tasks
  // ****************************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One Avalon transfer; waitrequest and answer sampled at the rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    rdat     = avs_readdata_o;
    last_err = avs_response_err_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask : rdc

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : idle

  // ****************************************************************************
  // Test sequence
  // ****************************************************************************
  initial begin
    rstn_i = 1'b0; avs_read_i = 1'b0; avs_write_i = 1'b0; avs_address_i = 8'h00; avs_writedata_i = 32'h0;
    tsr_out_i = 1'b0; rx_char_i = 1'b0; tx_char_i = 1'b0; ring_n = 1'b1; carrier_n = 1'b1; lag = 4'h0;
    idle(5);
    chk("rts_n rst", 1, rts_n);
    chk("dtr_n rst", 1, dtr_n);
    chk("irq_oe rst", 0, irq_oe_o);
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rdc("hs_ctrl rst", HS_CTRL_OFS, 32'hFFFF_FFFF, 32'h0);
    rdc("line_ctrl rst", LINE_CTRL_OFS, 32'h3, 32'h0);
    // Every word length code, data bits only
    for (int c = 0; c < 4; c++) begin
      wr(LINE_CTRL_OFS, c);
      idle(0);
      chk("word_len", c, word_len_o);
      chk("data_bits", 5 + c, data_bits_o);
      rdc("line_ctrl", LINE_CTRL_OFS, 32'h3, c);
    end
    // Handshake outputs outside loopback
    wr(HS_CTRL_OFS, 32'h03);
    idle(0);
    chk("rts_n", 0, rts_n);
    chk("dtr_n", 0, dtr_n);
    wr(HS_CTRL_OFS, 32'h02);
    idle(0);
    chk("dtr_n", 1, dtr_n);
    chk("rts_n", 0, rts_n);
    wr(HS_CTRL_OFS, 32'h04);
    idle(0);
    chk("pins aux1", 2'b11, {rts_n, dtr_n});
    chk("irq_oe off", 0, irq_oe_o);
    rdc("aux1 store", HS_CTRL_OFS, 32'hFF, 32'h04);
    wr(HS_CTRL_OFS, 32'h08);
    idle(0);
    chk("irq_oe on", 1, irq_oe_o);
    // Reserved bits, then loopback with every output bit set
    wr(HS_CTRL_OFS, 32'hFF);
    rdc("hs reserved", HS_CTRL_OFS, 32'hFFFF_FFFF, 32'h1F);
    idle(0);
    chk("pins loop", 2'b11, {rts_n, dtr_n});
    for (int t = 0; t < 2; t++) begin
      @(posedge ref_clk_i);
      tsr_out_i <= t[0];
      idle(0);
      chk("ser_tx loop", 1, ser_tx_o);
      chk("rsr_in loop", t, rsr_in_o);
    end
    idle(10);
    rdc("msr loop all", MODEM_STAT_OFS, 32'hF0, 32'hF0);
    wr(HS_CTRL_OFS, 32'h13);
    idle(10);
    rdc("msr loop rts dtr", MODEM_STAT_OFS, 32'hF0, 32'h30);
    rdc("msr flush", MODEM_STAT_OFS, 32'h0, 32'h0);
    ring_n <= 1'b0;
    carrier_n <= 1'b0;
    idle(10);
    rdc("msr pins cut", MODEM_STAT_OFS, 32'hFF, 32'h30);
    // Events in loopback come from control bits and shifter pulses
    wr(EVT_EN_OFS, 32'h7);
    wr(EVT_CLR_OFS, 32'h7);
    wr(HS_CTRL_OFS, 32'h11);
    idle(10);
    rdc("evt loop modem", EVT_STAT_OFS, 32'h1, 32'h1);
    @(posedge ref_clk_i);
    rx_char_i <= 1'b1;
    tx_char_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_char_i <= 1'b0;
    tx_char_i <= 1'b0;
    rdc("evt loop rx tx", EVT_STAT_OFS, 32'h6, 32'h6);
    // Pin change raises a modem event with a slow modem answering
    ring_n <= 1'b1;
    carrier_n <= 1'b1;
    lag <= 4'h3;
    wr(HS_CTRL_OFS, 32'h00);
    idle(20);
    rdc("msr flush", MODEM_STAT_OFS, 32'h0, 32'h0);
    wr(EVT_CLR_OFS, 32'h7);
    idle(0);
    chk("evt_irq clear", 0, evt_irq_o);
    wr(HS_CTRL_OFS, 32'h02);
    idle(20);
    wr(IRQ_EN_OFS, 32'h4);
    idle(0);
    chk("irq modem", 1, irq_o);
    rdc("msr cts delta", MODEM_STAT_OFS, 32'hFF, 32'h11);
    rdc("msr delta gone", MODEM_STAT_OFS, 32'hFF, 32'h10);
    idle(0);
    chk("irq modem gone", 0, irq_o);
    chk("evt_irq set", 1, evt_irq_o);
    wr(EVT_EN_OFS, 32'h0);
    idle(0);
    chk("evt_irq masked", 0, evt_irq_o);
    wr(EVT_EN_OFS, 32'h1);
    wr(EVT_CLR_OFS, 32'h1);
    idle(0);
    chk("evt_irq cleared", 0, evt_irq_o);
    rdc("evt cleared", EVT_STAT_OFS, 32'h1, 32'h0);
    // Unmapped place answers zero with an error
    rdc("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0);
    chk("unmapped err", 1, last_err);
    close_out();
  end
endmodule : test_uart_modem_control_loopback
`default_nettype wire
